// ==== alu_defs.svh ====
// constants of the integer execution datapath
// assumes a 32-bit register bus and a byte-wide memory port
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH
// ==========================================
// register byte offsets
`define ALU_OFS_GR   8'h00
`define ALU_OFS_CMD  8'h20
`define ALU_OFS_IMM  8'h24
`define ALU_OFS_FLG  8'h28
`define ALU_OFS_STA  8'h2C
`define ALU_OFS_MAD  8'h30
`define ALU_GR_LAST  8'h1C
// ==========================================
// command word fields
`define ALU_C_OP     4:0
`define ALU_C_SZ     6:5
`define ALU_C_RD     10:7
`define ALU_C_RS     14:11
`define ALU_C_IMM    15
`define ALU_C_BREG   16
`define ALU_C_MEM    17
`define ALU_C_W      18
// ==========================================
// operand sizes
`define ALU_SZ_B     2'h1
`define ALU_SZ_W     2'h2
`define ALU_SZ_L     2'h3
`define ALU_SZ_ONE   2'h1
// ==========================================
// flag and status bit positions
`define ALU_F_N      3
`define ALU_F_Z      2
`define ALU_F_V      1
`define ALU_F_C      0
`define ALU_S_BUSY   0
`define ALU_S_ERR    1
// ==========================================
// register slices
`define ALU_LO_B     7:0
`define ALU_HI_B     15:8
`define ALU_LO_W     15:0
`define ALU_HI_W     31:16
`define ALU_BITNO    2:0
`define ALU_HALF_SEL 3
`define ALU_REG_NO   2:0
`define ALU_OP_LAST  5'h17
`endif

// ==== alu_pkg.sv ====
// types of the integer execution datapath
// assumes alu_defs.svh for field widths
package alu_pkg;
`include "alu_defs.svh"
	// operations, in command-code order from zero
	typedef enum logic [4:0] {
		compare_op, negate_op, sign_widen_op, zero_widen_op,
		and_op, or_op, xor_op, not_op,
		arith_left_shift, arith_right_shift,
		logic_left_shift, logic_right_shift,
		circular_left, circular_right,
		carry_circular_left, carry_circular_right,
		single_bit_force_one, single_bit_force_zero,
		single_bit_invert, single_bit_probe,
		carry_conjoin_bit, carry_conjoin_inverted_bit,
		unsigned_divide, signed_divide
	} alu_op_e;
	typedef enum logic [1:0] {st_idle, st_exec, st_mrd, st_mwr} alu_state_e;
	// memory byte request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [31:0] addr;
		logic [7:0]  wdata;
	} alu_mreq_s;
	// result of a single-bit operation
	typedef struct packed {
		logic       wr;
		logic [7:0] v;
		logic [3:0] f;
	} alu_bres_s;
	// whole state of the core
	typedef struct packed {
		logic [7:0][31:0] gr;
		logic [3:0]       flg;
		logic [`ALU_C_W-1:0] cmd;
		logic [31:0]      imm;
		logic [31:0]      maddr;
		alu_state_e       st;
		logic             err;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
		alu_mreq_s        mreq;
	} alu_st_s;
endpackage : alu_pkg

// ==== alu_core.sv ====
// integer datapath: divide, compare, negate, widen, logic, shift, bit ops
// assumes an APB master as sequencer and a same-clock memory byte port
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "alu_defs.svh"
// What this block does
// (RULE1) unsigned divide 16/8 to 8+8 or 32/16 to 16+16 bits
// (RULE2) signed divide in the same two forms, two's complement
// (RULE3) compare subtracts, sets flags, destination untouched
// (RULE4) negate writes zero minus the operand
// (RULE5) sign widen byte to word or word to long
// (RULE6) zero widen byte to word or word to long
// (RULE7) bitwise and with register or immediate
// (RULE8) bitwise or with register or immediate
// (RULE9) bitwise exclusive or with register or immediate
// (RULE10) one's complement of a register
// (RULE11) arithmetic shifts, right shift keeps the sign
// (RULE12) logical shifts insert zero
// (RULE13) rotates feed the outgoing bit back in
// (RULE14) carry rotates pass through the carry flag
// (RULE15) force one selected byte bit to one
// (RULE16) force one selected byte bit to zero
// (RULE17) invert one selected byte bit
// (RULE18) probe sets zero flag to inverse of the bit
// (RULE19) bit number from 3-bit immediate or low bits of register
// (RULE20) carry becomes carry and the selected bit
// (RULE21) carry and inverted bit, immediate bit number only
// (RULE22) each operation accepts only its own sizes
// (RULE23) flags hold negative, zero, overflow and carry
// (RULE24) eight 32-bit registers, word halves and byte halves
// (RULE25) logic ops set N and Z, clear V, keep C
// (RULE26) zero divisor sets Z, destination left unchanged
// (RULE27) shifts put the outgoing bit in carry, set N and Z
// (RULE28) memory bit ops read, modify, write; probe and carry forms read
module alu_core
	import alu_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output alu_mreq_s        mem_req,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        mem_ack
);
	// ==========================================
	// helper functions
	// operand mask for a size
	function automatic logic [31:0] szmask(input logic [1:0] s);
		case (s)
			`ALU_SZ_B: szmask = 32'h000000FF;
			`ALU_SZ_W: szmask = 32'h0000FFFF;
			default:   szmask = 32'hFFFFFFFF;
		endcase
	endfunction : szmask

	// sign bit of a value at a size
	function automatic logic msb(input logic [31:0] v, input logic [1:0] s);
		case (s)
			`ALU_SZ_B: msb = v[7];
			`ALU_SZ_W: msb = v[15];
			default:   msb = v[31];
		endcase
	endfunction : msb

	// sign extend from a size to 32 bits
	function automatic logic [31:0] sext(input logic [31:0] v, input logic [1:0] s);
		case (s)
			`ALU_SZ_B: sext = {{24{v[7]}}, v[`ALU_LO_B]};
			`ALU_SZ_W: sext = {{16{v[15]}}, v[`ALU_LO_W]};
			default:   sext = v;
		endcase
	endfunction : sext

	// read a register as byte, word or long, zero-filled
	function automatic logic [31:0] rget(input logic [7:0][31:0] g,
		input logic [3:0] i, input logic [1:0] s);
		logic [31:0] w;
		w = g[i[`ALU_REG_NO]];
		case (s) // (RULE24)
			`ALU_SZ_B: rget = i[`ALU_HALF_SEL] ? {24'h000000, w[`ALU_LO_B]}
				: {24'h000000, w[`ALU_HI_B]};
			`ALU_SZ_W: rget = i[`ALU_HALF_SEL] ? {16'h0000, w[`ALU_HI_W]}
				: {16'h0000, w[`ALU_LO_W]};
			default:   rget = w;
		endcase
	endfunction : rget

	// merge a value into the addressed part of a register word
	function automatic logic [31:0] rput(input logic [31:0] w,
		input logic [3:0] i, input logic [1:0] s, input logic [31:0] v);
		rput = w;
		case (s) // (RULE24)
			`ALU_SZ_B: if (i[`ALU_HALF_SEL]) rput[`ALU_LO_B] = v[`ALU_LO_B];
				else rput[`ALU_HI_B] = v[`ALU_LO_B];
			`ALU_SZ_W: if (i[`ALU_HALF_SEL]) rput[`ALU_HI_W] = v[`ALU_LO_W];
				else rput[`ALU_LO_W] = v[`ALU_LO_W];
			default: rput = v;
		endcase
	endfunction : rput

	// sizes each operation accepts
	function automatic logic size_ok(input alu_op_e o, input logic [1:0] s);
		case (o) // (RULE22)
			sign_widen_op, zero_widen_op:
				size_ok = (s == `ALU_SZ_W) || (s == `ALU_SZ_L);
			unsigned_divide, signed_divide:
				size_ok = (s == `ALU_SZ_B) || (s == `ALU_SZ_W);
			single_bit_force_one, single_bit_force_zero, single_bit_invert,
			single_bit_probe, carry_conjoin_bit, carry_conjoin_inverted_bit:
				size_ok = (s == `ALU_SZ_B);
			default: size_ok = (s != 2'h0);
		endcase
	endfunction : size_ok

	// single-bit operation on a byte; shared by register and memory forms
	function automatic alu_bres_s bit_apply(input alu_op_e o,
		input logic [7:0] v, input logic [2:0] n, input logic [3:0] f);
		logic [7:0] sel;
		sel = 8'h01 << n;
		bit_apply.wr = (o <= single_bit_invert); // probe and carry forms only read
		bit_apply.v = v;
		bit_apply.f = f;
		case (o)
			single_bit_force_one:  bit_apply.v = v | sel;   // (RULE15)
			single_bit_force_zero: bit_apply.v = v & ~sel;  // (RULE16)
			single_bit_invert:     bit_apply.v = v ^ sel;   // (RULE17)
			single_bit_probe:      bit_apply.f[`ALU_F_Z] = ~|(v & sel); // (RULE18)
			carry_conjoin_bit:     bit_apply.f[`ALU_F_C] = f[`ALU_F_C] & |(v & sel); // (RULE20)
			default:               bit_apply.f[`ALU_F_C] = f[`ALU_F_C] & ~|(v & sel); // (RULE21)
		endcase
	endfunction : bit_apply

	// ==========================================
	// state
	localparam alu_st_s ALU_RST = '0;
	alu_st_s q;
	alu_st_s next_q;

	// ==========================================
	// next-state logic
	always_comb
	begin
		alu_op_e     op;
		logic [1:0]  sz, wsz;
		logic [3:0]  rd;
		logic [31:0] a, b, r, m, top, dd, dv, qt, rm;
		logic [2:0]  bn;
		logic        fill, wr, bad;
		alu_bres_s   br;
		op = alu_op_e'(q.cmd[`ALU_C_OP]);
		sz = q.cmd[`ALU_C_SZ];
		wsz = sz;
		rd = q.cmd[`ALU_C_RD];
		m = szmask(sz);
		top = ~(m >> 1) & m;
		a = rget(q.gr, rd, sz);
		b = q.cmd[`ALU_C_IMM] ? (q.imm & m) : rget(q.gr, q.cmd[`ALU_C_RS], sz);
		r = 32'h00000000;
		dd = 32'h00000000;
		dv = 32'h00000000;
		qt = 32'h00000000;
		rm = 32'h00000000;
		bn = 3'h0;
		fill = 1'b0;
		wr = 1'b0;
		bad = 1'b0;
		br = '0;
		next_q = q;
		next_q.pready = 1'b0;
		next_q.pslverr = 1'b0;

		// bus slave: answer one cycle into the access phase
		if (psel && penable && !q.pready)
		begin
			next_q.pready = 1'b1;
			next_q.prdata = 32'h00000000;
			if (paddr[1:0] != 2'h0 || paddr > `ALU_OFS_MAD)
				next_q.pslverr = 1'b1;
			else if (paddr <= `ALU_GR_LAST)
				next_q.prdata = q.gr[paddr[4:2]];
			else
				case (paddr)
					`ALU_OFS_CMD: next_q.prdata = 32'(q.cmd);
					`ALU_OFS_IMM: next_q.prdata = q.imm;
					`ALU_OFS_FLG: next_q.prdata = 32'(q.flg); // (RULE23)
					`ALU_OFS_STA:
					begin
						next_q.prdata[`ALU_S_BUSY] = (q.st != st_idle);
						next_q.prdata[`ALU_S_ERR] = q.err;
					end
					default: next_q.prdata = q.maddr;
				endcase
		end
		// writes land on the completing edge; a command starts work
		if (psel && penable && q.pready && pwrite && !q.pslverr)
		begin
			if (paddr <= `ALU_GR_LAST)
				next_q.gr[paddr[4:2]] = pwdata;
			else
				case (paddr)
					`ALU_OFS_CMD: if (q.st == st_idle) // busy core ignores commands
					begin
						next_q.cmd = pwdata[`ALU_C_W-1:0];
						next_q.st = st_exec;
					end
					`ALU_OFS_IMM: next_q.imm = pwdata;
					`ALU_OFS_FLG: next_q.flg = pwdata[3:0];
					`ALU_OFS_MAD: next_q.maddr = pwdata;
					default: ;
				endcase
		end

		case (q.st)
			st_exec:
			begin
				next_q.st = st_idle;
				bad = !size_ok(op, sz) || (q.cmd[`ALU_C_OP] > `ALU_OP_LAST); // (RULE22)
				if (op == carry_conjoin_inverted_bit && q.cmd[`ALU_C_BREG])
					bad = 1'b1; // (RULE21)
				next_q.err = bad;
				if (!bad)
				begin
					case (op)
						compare_op, negate_op:
						begin
							if (op == negate_op)
								{a, b} = {32'h00000000, a}; // (RULE4)
							r = (a - b) & m;
							wr = (op == negate_op); // (RULE3)
							next_q.flg[`ALU_F_C] = (a < b);
							next_q.flg[`ALU_F_V] = (msb(a, sz) != msb(b, sz))
								&& (msb(r, sz) != msb(a, sz));
						end
						sign_widen_op, zero_widen_op:
						begin
							r = (op == sign_widen_op)
								? sext(a, 2'(sz - `ALU_SZ_ONE)) // (RULE5)
								: a & szmask(2'(sz - `ALU_SZ_ONE)); // (RULE6)
							r = r & m;
							wr = 1'b1;
							next_q.flg[`ALU_F_V] = 1'b0;
						end
						and_op, or_op, xor_op, not_op:
						begin
							case (op)
								and_op:  r = a & b;  // (RULE7)
								or_op:   r = a | b;  // (RULE8)
								xor_op:  r = a ^ b;  // (RULE9)
								default: r = ~a & m; // (RULE10)
							endcase
							wr = 1'b1;
							next_q.flg[`ALU_F_V] = 1'b0; // (RULE25)
						end
						arith_left_shift, logic_left_shift,
						circular_left, carry_circular_left:
						begin
							case (op)
								circular_left:       fill = msb(a, sz); // (RULE13)
								carry_circular_left: fill = q.flg[`ALU_F_C]; // (RULE14)
								default:             fill = 1'b0; // (RULE11) (RULE12)
							endcase
							r = ((a << 1) & m) | 32'(fill);
							wr = 1'b1;
							next_q.flg[`ALU_F_C] = msb(a, sz); // (RULE27)
							next_q.flg[`ALU_F_V] = 1'b0;
						end
						arith_right_shift, logic_right_shift,
						circular_right, carry_circular_right:
						begin
							case (op)
								arith_right_shift:    fill = msb(a, sz); // (RULE11)
								circular_right:       fill = a[0]; // (RULE13)
								carry_circular_right: fill = q.flg[`ALU_F_C]; // (RULE14)
								default:              fill = 1'b0; // (RULE12)
							endcase
							r = (a >> 1) | (fill ? top : 32'h00000000);
							wr = 1'b1;
							next_q.flg[`ALU_F_C] = a[0]; // (RULE27)
							next_q.flg[`ALU_F_V] = 1'b0;
						end
						unsigned_divide, signed_divide:
						begin
							// dividend is twice the divisor width
							wsz = 2'(sz + `ALU_SZ_ONE);
							dd = rget(q.gr, rd, wsz);
							dv = rget(q.gr, q.cmd[`ALU_C_RS], sz);
							if (op == signed_divide)
							begin
								dd = sext(dd, wsz);
								dv = sext(dv, sz);
							end
							// no trap on a zero divisor; destination kept as it was
							if ((dv & m) == 32'h00000000)
								next_q.flg[`ALU_F_Z] = 1'b1; // (RULE26)
							else
							begin
								qt = dd / dv; // (RULE1)
								rm = dd % dv;
								if (op == signed_divide)
								begin
									qt = 32'($signed(dd) / $signed(dv)); // (RULE2)
									rm = 32'($signed(dd) % $signed(dv));
								end
								r = (sz == `ALU_SZ_B)
									? {16'h0000, rm[`ALU_LO_B], qt[`ALU_LO_B]}
									: {rm[`ALU_LO_W], qt[`ALU_LO_W]};
								wr = 1'b1;
								next_q.flg[`ALU_F_Z] = 1'b0;
								next_q.flg[`ALU_F_N] = msb(qt, sz);
							end
						end
						default:
						begin
							// bit number source
							bn = q.imm[`ALU_BITNO]; // (RULE19)
							if (q.cmd[`ALU_C_BREG])
							begin
								r = rget(q.gr, q.cmd[`ALU_C_RS], `ALU_SZ_B);
								bn = r[`ALU_BITNO]; // (RULE19)
							end
							if (q.cmd[`ALU_C_MEM])
							begin
								// byte read first, modify after it returns
								next_q.mreq.rd = 1'b1; // (RULE28)
								next_q.mreq.addr = q.maddr;
								next_q.st = st_mrd;
								next_q.imm[`ALU_BITNO] = bn;
							end
							else
							begin
								br = bit_apply(op, a[`ALU_LO_B], bn, q.flg);
								next_q.flg = br.f;
								wr = br.wr;
								r = 32'(br.v);
							end
						end
					endcase
					// N and Z follow the result of compare, negate, widen, logic and shift ops
					if (op <= not_op || (op >= arith_left_shift && op <= carry_circular_right))
					begin
						next_q.flg[`ALU_F_N] = msb(r, sz); // (RULE25) (RULE27)
						next_q.flg[`ALU_F_Z] = (r & m) == 32'h00000000;
					end
					if (wr)
						next_q.gr[rd[`ALU_REG_NO]] = rput(q.gr[rd[`ALU_REG_NO]], rd, wsz, r);
				end
			end
			st_mrd: if (mem_ack)
			begin
				next_q.mreq.rd = 1'b0;
				br = bit_apply(op, mem_rdata, q.imm[`ALU_BITNO], q.flg);
				next_q.flg = br.f;
				next_q.st = st_idle;
				if (br.wr)
				begin
					// probe and carry forms stop after the read
					next_q.mreq.wr = 1'b1; // (RULE28)
					next_q.mreq.wdata = br.v;
					next_q.st = st_mwr;
				end
			end
			st_mwr: if (mem_ack)
			begin
				next_q.mreq.wr = 1'b0;
				next_q.st = st_idle;
			end
			default: ;
		endcase
	end

	// ==========================================
	// registers; ce low freezes everything, but a low rstn still loads ALU_RST
	always_ff @(posedge clk)
	begin
		if (!rstn)
			q <= ALU_RST;
		else if (ce)
			q <= next_q;
	end

	// outputs straight from flops
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign mem_req = q.mreq;
endmodule : alu_core

// ==== alu_monitor.sv ====
// concurrent checks on the bus and memory ports of the datapath
// assumes one clock, synchronous active-low reset, bound to alu_core
`timescale 1ns/1ps
// ==========================================
// checker
module alu_monitor
	import alu_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input alu_mreq_s        mem_req,
	input wire logic [7:0]  mem_rdata,
	input wire logic        mem_ack
);
	logic take;
	logic bad;
	// access edge that starts an answer; bad means unmapped or unaligned
	assign take = psel && penable && !pready && ce;
	assign bad  = paddr > 8'h30 || paddr[1:0] != 2'h0;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// ==========================================
	// bus answer
	property p_rdy_pulse;
		pready && ce |=> !pready;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse)
		else $error("pready stood longer than one cycle");
	property p_rdy_cause;
		$rose(pready) |-> $past(take);
	endproperty
	a_rdy_cause: assert property (p_rdy_cause)
		else $error("pready without an access");
	property p_good;
		take && !bad |=> pready && !pslverr;
	endproperty
	a_good: assert property (p_good)
		else $error("mapped access not answered cleanly");
	property p_bad;
		take && bad |=> pready && pslverr && prdata == 32'h0;
	endproperty
	a_bad: assert property (p_bad)
		else $error("bad address not refused");
	property p_err_pair;
		pslverr |-> pready;
	endproperty
	a_err_pair: assert property (p_err_pair)
		else $error("pslverr without pready");
	// ==========================================
	// memory byte handshake: read, then optional write
	property p_rd_hold;
		mem_req.rd && !mem_ack |=> mem_req.rd && $stable(mem_req.addr);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read request dropped before ack");
	property p_rd_drop;
		mem_req.rd && mem_ack && ce |=> !mem_req.rd;
	endproperty
	a_rd_drop: assert property (p_rd_drop)
		else $error("read request kept after ack");
	property p_wr_after;
		$rose(mem_req.wr) |-> $past(mem_req.rd && mem_ack);
	endproperty
	a_wr_after: assert property (p_wr_after)
		else $error("write not preceded by acked read");
	property p_wr_hold;
		mem_req.wr && !mem_ack |=> mem_req.wr && $stable(mem_req.wdata);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write request changed before ack");
	c_bad: cover property (take && bad);
	c_rd: cover property (mem_req.rd && mem_ack);
	c_wr: cover property (mem_req.wr && mem_ack);
endmodule : alu_monitor

bind alu_core alu_monitor mon_u (
	.clk(clk),
	.rstn(rstn),
	.ce(ce),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.mem_req(mem_req),
	.mem_rdata(mem_rdata),
	.mem_ack(mem_ack)
);

// ==== alu_mem_model.sv ====
// byte memory on the far side of the datapath
// assumes the datapath clock; ack is a one-cycle pulse after dly waits
`timescale 1ns/1ps
// ==========================================
// memory model
module alu_mem_model
	import alu_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [3:0] dly,
	input  alu_mreq_s       mem_req,
	output logic      [7:0] mem_rdata,
	output logic            mem_ack
);
	logic [7:0] mem [256];
	logic [3:0] cnt;
	int         wcnt;
	// data line toggles when not valid, so a stale byte never passes
	always @(posedge clk) // not always_ff: the bench preloads mem from outside
	begin
		mem_ack   <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (!rstn)
			mem_rdata <= 8'hA5;
		if (!rstn || mem_ack)
			cnt <= 4'h0;
		else if (mem_req.rd || mem_req.wr)
		begin
			cnt <= cnt + 4'h1;
			if (cnt == dly)
			begin
				mem_ack <= 1'b1;
				if (mem_req.rd)
					mem_rdata <= mem[mem_req.addr[7:0]];
				if (mem_req.wr)
				begin
					mem[mem_req.addr[7:0]] <= mem_req.wdata;
					wcnt <= wcnt + 1;
				end
			end
		end
	end
endmodule : alu_mem_model

// ==== test_cpu_alu_logic_shift_bit_ops.sv ====
// self-checking bench of the integer datapath
// assumes alu_monitor bound to alu_core, alu_mem_model as memory
`timescale 1ns/1ps
// ==========================================
// bench top
module test_cpu_alu_logic_shift_bit_ops
	import alu_pkg::*;
;
	logic        clk, rstn, ce, psel, penable, pwrite, pready, pslverr, mem_ack;
	logic        err, bg, ef;
	logic [7:0]  paddr, mem_rdata;
	logic [31:0] pwdata, prdata, lf, a, b, x, y, e;
	logic [35:0] r;
	logic [4:0]  o;
	logic [3:0]  dly;
	alu_mreq_s   mem_req;
	int          miscompares, tests_run, n, w;
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	alu_core dut_u (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mem_req(mem_req),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack));
	alu_mem_model model_u (.clk(clk), .rstn(rstn), .dly(dly), .mem_req(mem_req),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack));
	// ==========================================
	// helpers
	function automatic logic [31:0] nr();
		lf = {1'b0, lf[31:1]} ^ (lf[0] ? 32'h80200003 : 32'h0);
		return lf;
	endfunction : nr
	// long-size reference: {N, Z, V, C, result}; compare and negate subtract s - t
	function automatic logic [35:0] ref_l(input logic [4:0] o, input logic [31:0] a, b,
		input logic c);
		logic [31:0] s, t, d;
		s = (o == 5'h1) ? 32'h0 : a;
		t = (o == 5'h1) ? a : b;
		case (o)
			0, 1:    d = s - t;
			2:       d = {{16{a[15]}}, a[15:0]};
			3:       d = {16'h0, a[15:0]};
			4:       d = a & b;
			5:       d = a | b;
			6:       d = a ^ b;
			7:       d = ~a;
			8, 10:   d = {a[30:0], 1'b0};
			9:       d = {a[31], a[31:1]};
			11:      d = {1'b0, a[31:1]};
			12:      d = {a[30:0], a[31]};
			13:      d = {a[0], a[31:1]};
			14:      d = {a[30:0], c};
			default: d = {c, a[31:1]};
		endcase
		c = (o < 2) ? s < t : (o < 8) ? c : o[0] ? a[0] : a[31];
		return {d[31], d == 0, (o < 2) && s[31] != t[31] && d[31] != s[31], c,
			(o == 5'h0) ? a : d};
	endfunction : ref_l
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
		tests_run++;
		if (g !== ex)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, g);
		end
	endtask : chk
	// one bus transfer; holds the request until pready is sampled
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 40);
		x = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k >= 40)
		begin
			miscompares++;
			$display("[FAIL] pready expected 1 seen %b", pready);
		end
	endtask : apb
	// command write, then poll busy
	task automatic cmd(input logic [4:0] op, input logic [1:0] sz, input logic [3:0] rd, rs,
		input logic [2:0] fm);
		int k;
		apb(1'b1, 8'h20, {14'h0, fm, rs, rd, sz, op});
		k = 0;
		do
		begin
			apb(1'b0, 8'h2C, 32'h0);
			k++;
		end
		while (x[0] !== 1'b0 && k < 40);
		if (k >= 40)
		begin
			miscompares++;
			$display("[FAIL] busy expected 0 seen %b", x[0]);
		end
	endtask : cmd
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	// ==========================================
	// watchdog: the whole run needs well under 20000 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end
	// ==========================================
	// main sequence
	initial
	begin
		{rstn, psel, penable, pwrite, paddr, pwdata, dly} = '0;
		ce = 1'b1;
		lf = 32'hB1CD;
		miscompares = 0;
		tests_run = 0;
		for (int i = 0; i < 256; i++)
			model_u.mem[i] = i[7:0];
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, 8'h28, 32'h0);
		chk("flags_reset", 32'h0, x);
		apb(1'b0, 8'h34, 32'h0);
		chk("unmapped", 32'h1, {x[31:1], err});
		$display("test reset and map done");
		// long ops; first rounds use the sign-bit corner and equal operands
		for (int k = 0; k < 64; k++)
		begin
			o = 5'(k % 16);
			a = k < 16 ? 32'h80000000 : nr();
			b = k < 32 && k >= 16 ? a : nr();
			y = nr();
			apb(1'b1, 8'h04, a);
			apb(1'b1, 8'h08, b);
			apb(1'b1, 8'h24, b);
			apb(1'b1, 8'h28, {28'h0, y[3:0]});
			cmd(o, 2'h3, 4'h1, 4'h2, {2'b0, y[4] && (o == 0 || (o > 3 && o < 7))});
			r = ref_l(o, a, b, y[0]);
			apb(1'b0, 8'h04, 32'h0);
			chk("result", r[31:0], x);
			apb(1'b0, 8'h28, 32'h0);
			chk("flags", {28'h0, r[35:32]}, x);
		end
		$display("test long ops done");
		// single-bit ops on a byte register, immediate then register bit number
		for (int k = 0; k < 24; k++)
		begin
			o = 5'(16 + k % 6);
			bg = (k / 6) % 2;
			a = nr();
			y = nr();
			apb(1'b1, 8'h0C, a);
			apb(1'b1, 8'h10, y);
			apb(1'b1, 8'h24, y);
			apb(1'b1, 8'h28, {28'h0, y[7:4]});
			cmd(o, 2'h1, 4'hB, 4'hC, {1'b0, bg, !bg});
			n = y[2:0];
			e = a;
			if (o == 16)
				e[n] = 1'b1;
			if (o == 17)
				e[n] = 1'b0;
			if (o == 18)
				e[n] = ~a[n];
			apb(1'b0, 8'h2C, 32'h0);
			chk("bit_err", {31'h0, o == 21 && bg}, {31'h0, x[1]});
			apb(1'b0, 8'h0C, 32'h0);
			chk("bit_reg", e, x);
			apb(1'b0, 8'h28, 32'h0);
			ef = o == 19 ? ~a[n] : o == 20 ? y[4] & a[n] : o == 21 && !bg ? y[4] & ~a[n] : y[4];
			if (o > 18)
				chk("bit_flag", {31'h0, ef}, {31'h0, o == 19 ? x[2] : x[0]});
		end
		$display("test bit ops done");
		// divide: unsigned byte, unsigned word, signed word, zero divisor
		for (int k = 0; k < 4; k++)
		begin
			a = nr() >> 1;
			b = nr() | 32'h8080;
			if (k == 0)
				a[15] = 1'b0;
			if (k == 2)
				a = $signed(nr()) >>> 3;
			if (k == 2)
				b[15:14] = 2'b10;
			if (k == 3)
				b = 32'h0;
			apb(1'b1, 8'h14, a);
			apb(1'b1, 8'h18, b);
			cmd(k == 2 ? 5'h17 : 5'h16, k == 0 ? 2'h1 : 2'h2, 4'h5, k == 0 ? 4'hE : 4'h6, 3'h0);
			e = {a[31:16], 8'(a[15:0] % b[7:0]), 8'(a[15:0] / b[7:0])};
			if (k == 1)
				e = {16'(a % b[15:0]), 16'(a / b[15:0])};
			if (k == 2)
				e = {16'($signed(a) % $signed(b[15:0])), 16'($signed(a) / $signed(b[15:0]))};
			if (k == 3)
				e = a;
			apb(1'b0, 8'h14, 32'h0);
			chk("divide", e, x);
			apb(1'b0, 8'h28, 32'h0);
			chk("div_zero", {31'h0, k == 3}, {31'h0, x[2]});
		end
		$display("test divide done");
		// memory operand: slow read-modify-write, then a prompt read-only probe
		dly <= 4'h3;
		apb(1'b1, 8'h30, 32'h40);
		apb(1'b1, 8'h24, 32'h0);
		cmd(5'h10, 2'h1, 4'hB, 4'hC, 3'h5);
		chk("mem_set", 32'h41, {24'h0, model_u.mem[64]});
		w = model_u.wcnt;
		dly <= 4'h0;
		apb(1'b1, 8'h24, 32'h6);
		cmd(5'h13, 2'h1, 4'hB, 4'hC, 3'h5);
		chk("probe_writes", w, model_u.wcnt);
		apb(1'b0, 8'h28, 32'h0);
		chk("probe_z", 32'h0, {31'h0, x[2]});
		// a bit op at long size is refused
		cmd(5'h10, 2'h3, 4'hB, 4'hC, 3'h1);
		apb(1'b0, 8'h2C, 32'h0);
		chk("size_err", 32'h1, {31'h0, x[1]});
		$display("test memory and refusal done");
		// clock enable low stalls a pending access; no answer until it returns
		n = 0;
		ce <= 1'b0;
		fork
			apb(1'b0, 8'h04, 32'h0);
			begin
				repeat (8)
				begin
					@(posedge clk);
					n += pready;
				end
				ce <= 1'b1;
			end
		join
		chk("ce_stall", 32'h0, n);
		chk("ce_answer", 32'h0, {31'h0, err});
		$display("test clock enable done");
		report_and_stop();
	end
endmodule : test_cpu_alu_logic_shift_bit_ops
